/* File: rf_bank_defs.vh */
// rf control register bank: register indices, field positions, reset values and timing counts.
// assumes a 125 MHz ref_clk; byte address on the bus is four times the register index.
`ifndef RF_BANK_DEFS_VH
`define RF_BANK_DEFS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_RX_STATUS 10'h030
`define IDX_CCA_THR 10'h03F
`define IDX_CHAN_RF 10'h200
`define IDX_VCO_OPT 10'h201
`define IDX_PLL_CTL 10'h202
`define IDX_TX_PWR 10'h203
`define IDX_BATT_THR 10'h205
`define IDX_FILT_REC 10'h206
`define IDX_SLP_SEL 10'h207
`define IDX_VCO_CTL 10'h208
`define IDX_CAL_LOW 10'h209
`define IDX_CAL_MID 10'h20A
`define IDX_CAL_HIGH 10'h20B
`define IDX_SLP_DIV 10'h220

// ----------------------------------------
// field positions
// ----------------------------------------
`define CHAN_MSB 7
`define CHAN_LSB 4
`define RADIO_OPTIMISE_FIELD_MSB 3
`define PLL_EN_BIT 7
`define PWR_COARSE_MSB 7
`define PWR_COARSE_LSB 6
`define PWR_FINE_MSB 5
`define PWR_FINE_LSB 3
`define BATT_MSB 7
`define BATT_LSB 4
`define TX_FILTER_CONTROL_BIT 7
`define RECOV_BIT 4
`define BATT_EN_BIT 3
`define SLP_SEL_MSB 7
`define SLP_SEL_LSB 6
`define VCO_CTL_BIT 4
`define CAL_DONE_BIT 7
`define CAL_START_BIT 4
`define SLP_DIV_MSB 4
`define SUPPLY_LOW_BIT 5

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RST_BYTE 8'h00
`define SEL_INT_OSC 2'h2
`define SEL_EXT_OSC 2'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 6'h08
`define CAL_TICK_NS 6'h32
`define CAL_PERIODS 5'h10

`endif

/* File: rf_bank_monitor.sv */
// checker: apb timing and field output properties of the rf control bank.
// assumes it is bound onto rf_control_register_bank and sees only its ports.
`timescale 1ns/1ps
module rf_bank_monitor (
	// clock and reset
	input logic ref_clk,
	input logic reset,
	// apb
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// modem side
	input logic [7:0] signal_strength,
	input logic tx_request,
	input logic channel_busy,
	input logic tx_enable,
	input logic rx_enable,
	// field outputs
	input logic [3:0] channel_code,
	input logic synth_lock_enable,
	input logic [8:0] tx_atten_tenth_db,
	input logic [8:0] supply_low_threshold_cv,
	input logic supply_low_flag
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	AST_ZERO_WAIT: assert property (psel && penable |-> pready)
		else $error("access without ready");
	AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access");
	AST_UPPER_ZERO: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	AST_NOT_BUSY: assert property ((signal_strength == 8'h00)[*6] |-> !channel_busy)
		else $error("busy with zero strength");
	AST_SYNTH_GATE: assert property ((!synth_lock_enable)[*2] |-> !tx_enable && !rx_enable)
		else $error("radio enabled with synth off");
	AST_NO_REQ: assert property ((!tx_request)[*4] |-> !tx_enable)
		else $error("transmit without request");
	AST_ATTEN_MAX: assert property (tx_atten_tenth_db <= 9'h16B)
		else $error("attenuation beyond table");
	AST_UNDEF_CODE: assert property ((supply_low_threshold_cv == 9'h000)[*2] |-> !supply_low_flag)
		else $error("low flag with undefined threshold");
	AST_CHAN_COPY: assert property (psel && penable && pready && pwrite && paddr == 12'h800
		|-> ##2 channel_code == $past(pwdata[7:4], 2))
		else $error("channel output not updated");
	AST_PLL_COPY: assert property (psel && penable && pready && pwrite && paddr == 12'h808
		|-> ##2 synth_lock_enable == $past(pwdata[7], 2))
		else $error("synth enable not updated");
endmodule

bind rf_control_register_bank rf_bank_monitor mon (.*);

/* File: rf_control_register_bank.v */
// rf control register bank: apb slave holding radio, power and sleep clock settings.
// assumes an apb master on ref_clk; modem and oscillator levels arrive from other domains.
`timescale 1ns/1ps
`include "rf_bank_defs.vh"

module rf_control_register_bank (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// modem side levels (asynchronous)
	input wire [7:0] signal_strength,
	input wire [8:0] supply_level,
	input wire tx_request,
	input wire rx_request,
	// sleep oscillators (asynchronous)
	input wire int_osc_clk,
	input wire ext_osc_clk,
	// radio controls
	output reg channel_busy,
	output reg tx_enable,
	output reg rx_enable,
	output reg [3:0] channel_code,
	output reg [3:0] radio_optimise_field,
	output reg [7:0] oscillator_optimise_field,
	output reg synth_lock_enable,
	output reg [8:0] tx_atten_tenth_db,
	output reg [8:0] supply_low_threshold_cv,
	output reg supply_low_flag,
	output reg tx_filter_control,
	output reg main_clock_recovery_fast,
	output reg oscillator_control_bit,
	output reg [1:0] sleep_clock_source
);

reg [7:0] cca_thr_r;
reg [7:0] chan_rf_r;
reg [7:0] vco_opt_r;
reg [7:0] pll_ctl_r;
reg [7:0] tx_pwr_r;
reg [7:0] batt_thr_r;
reg [7:0] filt_rec_r;
reg [7:0] slp_sel_r;
reg [7:0] vco_ctl_r;
reg [7:0] slp_div_r;
reg cal_start_r;
reg [7:0] rdata_nxt;
reg hit_nxt;
reg hit_r;
reg [7:0] ss_meta_r;
reg [7:0] ss_sync_r;
reg [8:0] sup_meta_r;
reg [8:0] sup_sync_r;
reg [1:0] req_meta_r;
reg [1:0] req_sync_r;
reg [7:0] ss_prev_r;
reg [7:0] ss_hold_r;
reg [8:0] sup_prev_r;
reg [8:0] sup_hold_r;
wire [1:0] osc_raw;
wire [1:0] osc_sync;
wire [9:0] idx;
wire aligned;
wire wr_en;
wire setup;
wire slp_level;
wire [19:0] cal_count;
wire cal_done;
wire [8:0] thr_cv;

// ----------------------------------------
// helpers
// ----------------------------------------
function [8:0] fine_tenths;
	input [2:0] code;
	begin
		case (code)
		3'd0: fine_tenths = 9'd0;
		3'd1: fine_tenths = 9'd5;
		3'd2: fine_tenths = 9'd12;
		3'd3: fine_tenths = 9'd19;
		3'd4: fine_tenths = 9'd28;
		3'd5: fine_tenths = 9'd37;
		3'd6: fine_tenths = 9'd49;
		default: fine_tenths = 9'd63;
		endcase
	end
endfunction

// supply threshold in units of 10 mV; zero marks an undefined code
function [8:0] supply_cv;
	input [3:0] code;
	begin
		case (code)
		4'h7: supply_cv = 9'd250;
		4'h8: supply_cv = 9'd260;
		4'h9: supply_cv = 9'd270;
		4'hA: supply_cv = 9'd280;
		4'hB: supply_cv = 9'd310;
		4'hC: supply_cv = 9'd320;
		4'hD: supply_cv = 9'd330;
		4'hE: supply_cv = 9'd350;
		default: supply_cv = 9'd0;
		endcase
	end
endfunction

// ----------------------------------------
// input synchronisers
// ----------------------------------------
assign osc_raw = {ext_osc_clk, int_osc_clk};

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : osc_sync_gen
		reg meta_r;
		reg sync_r;
		always @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				meta_r <= 1'b0;
				sync_r <= 1'b0;
			end else begin
				meta_r <= osc_raw[g];
				sync_r <= meta_r;
			end
		end
		assign osc_sync[g] = sync_r;
	end
endgenerate

// multi-bit levels are assumed to move slowly against ref_clk
always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		ss_meta_r <= 8'h00;
		ss_sync_r <= 8'h00;
		sup_meta_r <= 9'h000;
		sup_sync_r <= 9'h000;
		req_meta_r <= 2'h0;
		req_sync_r <= 2'h0;
	end else begin
		ss_meta_r <= signal_strength;
		ss_sync_r <= ss_meta_r;
		sup_meta_r <= supply_level;
		sup_sync_r <= sup_meta_r;
		req_meta_r <= {rx_request, tx_request};
		req_sync_r <= req_meta_r;
	end
end

// ----------------------------------------
// level word filter
// ----------------------------------------
// a word is taken only once two samples agree, so a
// level caught between bit changes never reaches a compare
always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		ss_prev_r <= 8'h00;
		ss_hold_r <= 8'h00;
		sup_prev_r <= 9'h000;
		sup_hold_r <= 9'h000;
	end else begin
		ss_prev_r <= ss_sync_r;
		sup_prev_r <= sup_sync_r;
		if (ss_sync_r == ss_prev_r)
			ss_hold_r <= ss_sync_r;
		if (sup_sync_r == sup_prev_r)
			sup_hold_r <= sup_sync_r;
	end
end

// ----------------------------------------
// apb decode
// ----------------------------------------
assign idx = paddr[11:2];
assign aligned = (paddr[1:0] == 2'h0);
assign setup = psel & ~penable;
assign wr_en = psel & penable & pwrite & hit_r;
// zero wait states: read data is captured in the setup cycle
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit_r;

always @* begin
	rdata_nxt = 8'h00;
	hit_nxt = aligned;
	case (idx)
	`IDX_RX_STATUS: rdata_nxt[`SUPPLY_LOW_BIT] = supply_low_flag;
	`IDX_CCA_THR: rdata_nxt = cca_thr_r;
	`IDX_CHAN_RF: rdata_nxt = chan_rf_r;
	`IDX_VCO_OPT: rdata_nxt = vco_opt_r;
	`IDX_PLL_CTL: rdata_nxt = pll_ctl_r;
	`IDX_TX_PWR: rdata_nxt = tx_pwr_r;
	`IDX_BATT_THR: rdata_nxt = batt_thr_r;
	`IDX_FILT_REC: rdata_nxt = filt_rec_r;
	`IDX_SLP_SEL: rdata_nxt = slp_sel_r;
	`IDX_VCO_CTL: rdata_nxt = vco_ctl_r;
	`IDX_CAL_LOW: rdata_nxt = cal_count[7:0];
	`IDX_CAL_MID: rdata_nxt = cal_count[15:8];
	`IDX_CAL_HIGH: rdata_nxt = {cal_done, 2'h0, cal_start_r, cal_count[19:16]};
	`IDX_SLP_DIV: rdata_nxt = slp_div_r;
	default: hit_nxt = 1'b0;
	endcase
	if (!aligned)
		rdata_nxt = 8'h00;
end

always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		prdata <= 32'h0;
		hit_r <= 1'b0;
	end else if (setup) begin
		prdata <= {24'h0, rdata_nxt};
		hit_r <= hit_nxt;
	end
end

// ----------------------------------------
// control registers
// ----------------------------------------
always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		cca_thr_r <= `RST_BYTE;
		chan_rf_r <= `RST_BYTE;
		vco_opt_r <= `RST_BYTE;
		pll_ctl_r <= `RST_BYTE;
		tx_pwr_r <= `RST_BYTE;
		batt_thr_r <= `RST_BYTE;
		filt_rec_r <= `RST_BYTE;
		slp_sel_r <= `RST_BYTE;
		vco_ctl_r <= `RST_BYTE;
		slp_div_r <= `RST_BYTE;
		cal_start_r <= 1'b0;
	end else begin
		cal_start_r <= 1'b0;
		if (wr_en) begin
			case (idx)
			`IDX_CCA_THR: cca_thr_r <= pwdata[7:0];
			`IDX_CHAN_RF: chan_rf_r <= pwdata[7:0];
			`IDX_VCO_OPT: vco_opt_r <= pwdata[7:0];
			`IDX_PLL_CTL: pll_ctl_r <= pwdata[7:0];
			`IDX_TX_PWR: tx_pwr_r <= pwdata[7:0];
			`IDX_BATT_THR: batt_thr_r <= pwdata[7:0];
			`IDX_FILT_REC: filt_rec_r <= pwdata[7:0];
			`IDX_SLP_SEL: slp_sel_r <= pwdata[7:0];
			`IDX_VCO_CTL: vco_ctl_r <= pwdata[7:0];
			`IDX_SLP_DIV: slp_div_r <= pwdata[7:0];
			`IDX_CAL_HIGH: cal_start_r <= pwdata[`CAL_START_BIT];
			default: cal_start_r <= 1'b0; // count bytes are read only
			endcase
		end
	end
end

// ----------------------------------------
// radio side outputs
// ----------------------------------------
assign thr_cv = supply_cv(batt_thr_r[`BATT_MSB:`BATT_LSB]);

always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		channel_busy <= 1'b0;
		tx_enable <= 1'b0;
		rx_enable <= 1'b0;
		channel_code <= 4'h0;
		radio_optimise_field <= 4'h0;
		oscillator_optimise_field <= 8'h00;
		synth_lock_enable <= 1'b0;
		tx_atten_tenth_db <= 9'h000;
		supply_low_threshold_cv <= 9'h000;
		supply_low_flag <= 1'b0;
		tx_filter_control <= 1'b0;
		main_clock_recovery_fast <= 1'b0;
		oscillator_control_bit <= 1'b0;
		sleep_clock_source <= 2'h0;
	end else begin
		channel_busy <= (ss_hold_r > cca_thr_r);
		synth_lock_enable <= pll_ctl_r[`PLL_EN_BIT];
		tx_enable <= req_sync_r[0] & pll_ctl_r[`PLL_EN_BIT];
		rx_enable <= req_sync_r[1] & pll_ctl_r[`PLL_EN_BIT];
		channel_code <= chan_rf_r[`CHAN_MSB:`CHAN_LSB];
		radio_optimise_field <= chan_rf_r[`RADIO_OPTIMISE_FIELD_MSB:0];
		oscillator_optimise_field <= vco_opt_r;
		// coarse steps are 10 dB, i.e. 100 tenths
		tx_atten_tenth_db <= 9'd100 * {7'h0, tx_pwr_r[`PWR_COARSE_MSB:`PWR_COARSE_LSB]}
			+ fine_tenths(tx_pwr_r[`PWR_FINE_MSB:`PWR_FINE_LSB]);
		supply_low_threshold_cv <= thr_cv;
		// undefined threshold codes never raise the flag
		supply_low_flag <= filt_rec_r[`BATT_EN_BIT] && (thr_cv != 9'd0)
			&& (sup_hold_r < thr_cv);
		tx_filter_control <= filt_rec_r[`TX_FILTER_CONTROL_BIT];
		main_clock_recovery_fast <= filt_rec_r[`RECOV_BIT];
		oscillator_control_bit <= vco_ctl_r[`VCO_CTL_BIT];
		sleep_clock_source <= slp_sel_r[`SLP_SEL_MSB:`SLP_SEL_LSB];
	end
end

// ----------------------------------------
// sleep clock calibration
// ----------------------------------------
// codes other than the two sources select no clock, so no edges arrive
assign slp_level = (sleep_clock_source == `SEL_INT_OSC) ? osc_sync[0] :
	(sleep_clock_source == `SEL_EXT_OSC) ? osc_sync[1] : 1'b0;

sleep_cal_counter u_cal (
	.ref_clk(ref_clk),
	.reset(reset),
	.slp_level(slp_level),
	.divisor(slp_div_r[`SLP_DIV_MSB:0]),
	.start(cal_start_r),
	.count_r(cal_count),
	.done_r(cal_done)
);

endmodule

/* File: sleep_cal_counter.v */
// sleep clock calibration: divides the chosen sleep clock and counts 50 ns ticks over 16 periods.
// assumes slp_level is already synchronised to ref_clk.
`timescale 1ns/1ps
`include "rf_bank_defs.vh"

module sleep_cal_counter (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// control
	input wire slp_level,
	input wire [4:0] divisor,
	input wire start,
	// result
	output reg [19:0] count_r,
	output reg done_r
);

localparam ST_IDLE = 2'd0;
localparam ST_ARM = 2'd1;
localparam ST_COUNT = 2'd2;
localparam [5:0] STEP = `CLK_PERIOD_NS;
localparam [5:0] TICK = `CAL_TICK_NS;
localparam [4:0] LAST_FULL = `CAL_PERIODS - 5'h01;
localparam [3:0] LAST_PERIOD = LAST_FULL[3:0];

reg [1:0] state_r;
reg slp_prev_r;
reg [31:0] div_cnt_r;
reg [5:0] acc_r;
reg [3:0] periods_r;
reg [19:0] run_r;
wire src_edge;
wire [31:0] div_mask;
wire div_edge;
wire [5:0] acc_sum;
wire tick;
wire finish;
wire [19:0] final_count;

// ----------------------------------------
// divided sleep clock
// ----------------------------------------
assign src_edge = slp_level & ~slp_prev_r;
assign div_mask = (32'h1 << divisor) - 32'h1;
assign div_edge = src_edge && (div_cnt_r == div_mask);

// 8 ns clock cannot count 50 ns exactly; a fractional accumulator averages it
assign acc_sum = acc_r + STEP;
assign tick = (acc_sum >= TICK);
// last divided edge of the sixteenth period closes the count
assign finish = (state_r == ST_COUNT) && div_edge && (periods_r == LAST_PERIOD);
assign final_count = run_r + {19'h0, tick};

always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		slp_prev_r <= 1'b0;
		div_cnt_r <= 32'h0;
	end else begin
		slp_prev_r <= slp_level;
		if (div_edge)
			div_cnt_r <= 32'h0;
		else if (src_edge)
			div_cnt_r <= div_cnt_r + 32'h1;
	end
end

// ----------------------------------------
// measurement sequence
// ----------------------------------------
always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		state_r <= ST_IDLE;
		acc_r <= 6'h0;
		periods_r <= 4'h0;
		run_r <= 20'h0;
		count_r <= 20'h0;
		done_r <= 1'b0;
	end else if (start) begin
		state_r <= ST_ARM;
		// a count closing as a restart lands still counts: the set wins
		if (finish) begin
			count_r <= final_count;
			done_r <= 1'b1;
		end else begin
			done_r <= 1'b0;
		end
	end else begin
		case (state_r)
		ST_IDLE: begin
			state_r <= ST_IDLE;
		end
		ST_ARM: begin
			if (div_edge) begin
				state_r <= ST_COUNT;
				acc_r <= 6'h0;
				periods_r <= 4'h0;
				run_r <= 20'h0;
			end
		end
		ST_COUNT: begin
			acc_r <= tick ? (acc_sum - TICK) : acc_sum;
			if (tick && run_r != 20'hFFFFF)
				run_r <= run_r + 20'h1;
			if (div_edge)
				periods_r <= periods_r + 4'h1;
			if (finish) begin
				count_r <= final_count;
				done_r <= 1'b1;
				state_r <= ST_IDLE;
			end
		end
		default: begin
			state_r <= ST_IDLE;
		end
		endcase
	end
end

endmodule

/* File: tb.sv */
// testbench: random and directed apb traffic against the rf control bank.
// assumes zero wait states are likely but always waits on pready.
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic ref_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, rnd = 32'h1, d;
	logic [7:0] signal_strength = 8'h00;
	logic [8:0] supply_level = 9'h1FF;
	logic tx_request = 1'h0, rx_request = 1'h0, int_osc_clk = 1'h0, ext_osc_clk = 1'h0, err;
	wire [31:0] prdata;
	wire pready, pslverr, channel_busy, tx_enable, rx_enable, synth_lock_enable;
	wire supply_low_flag, tx_filter_control, main_clock_recovery_fast, oscillator_control_bit;
	wire [3:0] channel_code, radio_optimise_field;
	wire [7:0] oscillator_optimise_field;
	wire [8:0] tx_atten_tenth_db, supply_low_threshold_cv;
	wire [1:0] sleep_clock_source;
	int err_total = 0, n_compared = 0, cyc = 0, n, ex;
	logic [19:0] cnt;
	logic [7:0] v [11];
	logic [3:0] cs [3] = '{4'h6, 4'h7, 4'hE};
	// last two places are the read-only count bytes
	logic [11:0] addr [11] = '{12'h0FC, 12'h800, 12'h804, 12'h808, 12'h80C, 12'h814,
		12'h818, 12'h81C, 12'h820, 12'h824, 12'h828};
	logic [7:0] mask [11] = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'hF8, 8'hF0, 8'h98, 8'hC0,
		8'h10, 8'h00, 8'h00};

	rf_control_register_bank dut (.*);

	// ----------------------------------------
	// clock, oscillators, timeout
	// ----------------------------------------
	always #4 ref_clk = ~ref_clk;
	// oscillators locked to ref_clk keep the expected count exact
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc % 25 == 0)
			int_osc_clk <= ~int_osc_clk;
		if (cyc % 50 == 0)
			ext_osc_clk <= ~ext_osc_clk;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction
	function automatic logic [8:0] atten(input logic [7:0] c);
		logic [8:0] f [8] = '{9'h000, 9'h005, 9'h00C, 9'h013, 9'h01C, 9'h025, 9'h031, 9'h03F};
		return 9'(c[7:6]) * 9'h064 + f[c[5:3]];
	endfunction
	function automatic logic [8:0] cv(input logic [3:0] c);
		logic [8:0] t [8] = '{9'h0FA, 9'h104, 9'h10E, 9'h118, 9'h136, 9'h140, 9'h14A, 9'h15E};
		return (c >= 4'h7 && c <= 4'hE) ? t[c - 4'h7] : 9'h000;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'h1;
		@(posedge ref_clk);
		while (pready !== 1'h1)
			@(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic complete_run();
		if (err_total == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		foreach (addr[i]) begin
			apb(1'h0, addr[i], 32'h0);
			check(rd, 32'h0);
		end
		// first pass all ones, then random; reserved bits kept zero by the host except at the read-only count bytes, which get the whole word
		for (int it = 0; it < 8; it++) begin
			foreach (addr[i]) begin
				d = (it == 0) ? 32'hFFFFFFFF : xs();
				v[i] = d[7:0] & mask[i];
				apb(1'h1, addr[i], (mask[i] == 8'h00) ? d : {24'h0, v[i]});
			end
			foreach (addr[i]) begin
				apb(1'h0, addr[i], 32'h0);
				check(rd, {24'h0, v[i]});
			end
			check(channel_code, v[1][7:4]);
			check(radio_optimise_field, v[1][3:0]);
			check(oscillator_optimise_field, v[2]);
			check(synth_lock_enable, v[3][7]);
			check(tx_atten_tenth_db, atten(v[4]));
			check(supply_low_threshold_cv, cv(v[5][7:4]));
			check(tx_filter_control, v[6][7]);
			check(main_clock_recovery_fast, v[6][4]);
			check(oscillator_control_bit, v[8][4]);
			check(sleep_clock_source, v[7][7:6]);
		end
		apb(1'h0, 12'h004, 32'h0);
		check(err, 1'h1);
		check(rd, 32'h0);
		apb(1'h1, 12'h0FC, 32'h60);
		signal_strength <= 8'h61;
		repeat (8) @(posedge ref_clk);
		check(channel_busy, 1'h1);
		signal_strength <= 8'h60;
		repeat (8) @(posedge ref_clk);
		check(channel_busy, 1'h0);
		apb(1'h1, 12'h808, 32'h0);
		tx_request <= 1'h1;
		rx_request <= 1'h1;
		repeat (5) @(posedge ref_clk);
		check({tx_enable, rx_enable}, 2'h0);
		apb(1'h1, 12'h808, 32'h80);
		repeat (4) @(posedge ref_clk);
		check({tx_enable, rx_enable}, 2'h3);
		apb(1'h1, 12'h818, 32'h08);
		foreach (cs[k]) begin
			apb(1'h1, 12'h814, {24'h0, cs[k], 4'h0});
			supply_level <= cv(cs[k]) - 9'h001;
			repeat (8) @(posedge ref_clk);
			check(supply_low_flag, cv(cs[k]) != 9'h000);
			apb(1'h0, 12'h0C0, 32'h0);
			check(rd, {26'h0, cv(cs[k]) != 9'h000, 5'h00});
			supply_level <= cv(cs[k]);
			repeat (8) @(posedge ref_clk);
			check(supply_low_flag, 1'h0);
		end
		apb(1'h1, 12'h818, 32'h00);
		supply_level <= 9'h000;
		repeat (5) @(posedge ref_clk);
		check(supply_low_flag, 1'h0);
		// internal source at 400 ns, then external at 800 ns, both divided by two
		for (int k = 0; k < 2; k++) begin
			apb(1'h1, 12'h81C, k ? 32'h40 : 32'h80);
			apb(1'h1, 12'h880, 32'h1);
			apb(1'h1, 12'h82C, 32'h10);
			apb(1'h0, 12'h82C, 32'h0);
			check(rd[4], 1'h0);
			n = 0;
			do begin
				apb(1'h0, 12'h82C, 32'h0);
				n++;
			end while (rd[7] !== 1'h1 && n < 3000);
			check(rd[7], 1'h1);
			cnt[19:16] = rd[3:0];
			apb(1'h0, 12'h828, 32'h0);
			cnt[15:8] = rd[7:0];
			apb(1'h0, 12'h824, 32'h0);
			cnt[7:0] = rd[7:0];
			ex = 16 * 2 * (k ? 800 : 400) / 50;
			check(cnt > ex - 6 && cnt < ex + 6, 1'h1);
			apb(1'h1, 12'h824, 32'hFF);
			apb(1'h0, 12'h824, 32'h0);
			check(rd, {24'h0, cnt[7:0]});
		end
		complete_run();
	end
endmodule
